//--- rtl/perf_event_pkg.sv
// Event codes, field positions and encodings for the interface event source
package perf_event_pkg;
	localparam int code_width = 6;
	localparam int event_count = 64;
	localparam int bus_width = 8;
	typedef logic [code_width-1:0] code_type;
	// Shared codes; 0x01 and 0x08 are raised on the subordinate side only
	localparam code_type ev_rd_req = 6'h00;
	localparam code_type ev_rd_device = 6'h01;
	localparam code_type ev_rd_nosnoop = 6'h02;
	localparam code_type ev_rd_once = 6'h03;
	localparam code_type ev_cmo = 6'h04;
	localparam code_type ev_rd_beat = 6'h05;
	localparam code_type ev_rd_last = 6'h06;
	localparam code_type ev_wr_req = 6'h07;
	localparam code_type ev_wr_device = 6'h08;
	localparam code_type ev_wr_nosnoop = 6'h09;
	localparam code_type ev_wr_line_unique = 6'h0A;
	localparam code_type ev_wr_unique = 6'h0B;
	localparam code_type ev_wr_atomic = 6'h0C;
	localparam code_type ev_wr_beat = 6'h0D;
	localparam code_type ev_ar_stall = 6'h0E;
	localparam code_type ev_r_stall = 6'h0F;
	localparam code_type ev_aw_stall = 6'h10;
	localparam code_type ev_w_stall = 6'h11;
	localparam code_type ev_b_stall = 6'h12;
	localparam code_type ev_wr_stash = 6'h13;
	localparam code_type ev_cmo_plain = 6'h14;
	localparam code_type ev_cmo_persist = 6'h15;
	localparam code_type ev_rd_tag = 6'h16;
	localparam code_type ev_wr_tag = 6'h17;
	// Manager-side codes
	localparam code_type ev_m_rd_tracker = 6'h20;
	localparam code_type ev_m_wr_tracker = 6'h21;
	localparam code_type ev_m_b_credit = 6'h22;
	localparam code_type ev_m_r_credit = 6'h23;
	localparam code_type ev_m_b_lowwire = 6'h24;
	localparam code_type ev_m_r_lowwire = 6'h25;
	// Subordinate-side codes
	localparam code_type ev_s_ot_limit = 6'h20;
	localparam code_type ev_s_bw_limit = 6'h21;
	localparam code_type ev_s_atomic_arb = 6'h22;
	localparam code_type ev_s_rd_tracker = 6'h23;
	localparam code_type ev_s_wr_tracker = 6'h24;
	localparam code_type ev_s_wbuf_full = 6'h25;
	localparam code_type ev_s_rob_full = 6'h26;
	localparam code_type ev_s_aw_order = 6'h27;
	localparam code_type ev_s_ar_order = 6'h28;
	localparam code_type ev_s_atomic_rd = 6'h29;
	localparam code_type ev_s_aw_credit = 6'h2A;
	localparam code_type ev_s_ar_credit = 6'h2B;
	localparam code_type ev_s_aw_ot = 6'h2C;
	localparam code_type ev_s_ar_ot = 6'h2D;
	localparam code_type ev_s_aw_bw = 6'h2E;
	localparam code_type ev_s_ar_bw = 6'h2F;
	localparam code_type ev_s_w_lowwire = 6'h30;
	localparam code_type ev_s_r_lowwire = 6'h31;
	// Request attribute encodings
	localparam int cache_dev_hi = 3;
	localparam int cache_dev_lo = 1;
	localparam logic [2:0] cache_device = 3'h0;
	localparam logic [3:0] snoop_read_nosnoop = 4'h0;
	localparam logic [3:0] snoop_read_once = 4'h0;
	localparam logic [3:0] snoop_clean_shared = 4'h8;
	localparam logic [3:0] snoop_clean_invalid = 4'h9;
	localparam logic [3:0] snoop_make_invalid = 4'hD;
	localparam logic [3:0] snoop_clean_shared_persist = 4'hA;
	localparam logic [3:0] snoop_write_nosnoop = 4'h0;
	localparam logic [3:0] snoop_write_unique = 4'h0;
	localparam logic [3:0] snoop_write_line_unique = 4'h1;
	localparam logic [3:0] snoop_wcmo_a = 4'h6;
	localparam logic [3:0] snoop_wcmo_b = 4'hA;
	localparam logic [3:0] snoop_wcmo_c = 4'hB;
	localparam logic [3:0] snoop_stash_a = 4'hC;
	localparam logic [3:0] snoop_stash_b = 4'hD;
	localparam logic [1:0] domain_noshare = 2'h0;
	localparam logic [1:0] domain_system = 2'h3;
	localparam logic [1:0] cmo_persist = 2'h2;
	localparam logic [1:0] cmo_deep_persist = 2'h3;
	localparam logic [1:0] tag_none = 2'h0;
	localparam logic [5:0] atop_none = 6'h00;
endpackage

//--- rtl/secure_debug_gate.sv
// Debug-enable qualification of event enables
`timescale 1ns/1ps
module secure_debug_gate (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Debug enables
	input wire logic invasive_debug_enable,
	input wire logic noninvasive_debug_enable,
	input wire logic secure_invasive_debug_enable,
	input wire logic secure_noninvasive_debug_enable,
	// Qualified enables
	output logic debug_on,
	output logic secure_on
);
	typedef struct packed {
		logic debug;
		logic secure;
	} state_type;
	state_type state_q, state_d;
	always_comb begin
		state_d.debug = invasive_debug_enable | noninvasive_debug_enable;
		state_d.secure = ((secure_invasive_debug_enable & invasive_debug_enable)
			| secure_noninvasive_debug_enable) & state_d.debug;
		if (reset) begin
			state_d = '0;
		end
	end
	always_ff @(posedge clock) begin
		state_q <= state_d;
	end
	assign debug_on = state_q.debug;
	assign secure_on = state_q.secure;
	a_secure_needs_debug: assert property (@(posedge clock) disable iff (reset)
		secure_on |-> debug_on) else $error("secure enable without debug enable");
	a_debug_follows: assert property (@(posedge clock) disable iff (reset)
		(invasive_debug_enable | noninvasive_debug_enable) |=> debug_on) else $error("debug enable missed");
endmodule

//--- rtl/event_select.sv
// Selects up to eight of 64 event lines onto the counter bus
`timescale 1ns/1ps
module event_select
	import perf_event_pkg::*;
#(
	parameter int lanes = perf_event_pkg::bus_width
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Event lines and per-lane codes
	input wire logic [perf_event_pkg::event_count-1:0] events,
	input wire logic [lanes*perf_event_pkg::code_width-1:0] lane_code,
	input wire logic [lanes-1:0] lane_enable,
	// Counter bus, bit n to counter n
	output logic [lanes-1:0] event_bus
);
	typedef struct packed {
		logic [lanes-1:0] bus;
	} state_type;
	state_type state_q, state_d;
	logic [lanes-1:0] pick;
	genvar g;
	generate
		for (g = 0; g < lanes; g++) begin : lane
			assign pick[g] = lane_enable[g] & events[lane_code[g*code_width +: code_width]];
		end
	endgenerate
	always_comb begin
		state_d.bus = reset ? '0 : pick;
	end
	always_ff @(posedge clock) begin
		state_q <= state_d;
	end
	assign event_bus = state_q.bus;
	a_lane_follows: assert property (@(posedge clock) disable iff (reset)
		event_bus[0] == $past(pick[0])) else $error("lane 0 not one cycle behind");
endmodule

//--- rtl/axi_ni_perf_event_source.sv
// Performance event source for an AXI-facing network interface
`timescale 1ns/1ps
// Summary of operation
// - Read address handshake raises 0x00; write address handshake raises 0x07.
// - Every read beat raises 0x05; read beats with last raise 0x06.
// - Every write data beat handshake raises 0x0D.
// - AR valid without ready raises 0x0E; AW likewise raises 0x10.
// - Stalls per cycle: R 0x0F, W 0x11, B 0x12.
// - Subordinate side: device reads (cache 3:1 zero) 0x01; device writes 0x08.
// - Write CMO snoop types: non-persist on 0x14, persist kinds on 0x15.
// - Reads with tag operation 0x16; writes with tag operation 0x17.
// - Non-snooping reads 0x02 and writes 0x09.
// - Read-once 0x03, write-line-unique 0x0A, write-unique 0x0B.
// - Cache maintenance reads 0x04; persist variant only with the newer protocol.
// - Atomic writes 0x0C; stash writes 0x13.
// - Tracker stalls: manager 0x20 and 0x21, subordinate 0x23 and 0x24.
// - Manager: write response credit stall 0x22, read response 0x23.
// - Low-wire stalls: manager B 0x24, R 0x25; subordinate W 0x30, R 0x31.
// - Subordinate: outstanding limit stall 0x20, bandwidth limit stall 0x21.
// - Subordinate: atomic resource collision stall 0x22.
// - Subordinate: write buffer full 0x25, reorder buffer full 0x26.
// - Subordinate: ordering stalls AW 0x27, AR 0x28; atomic read stall 0x29.
// - Subordinate: write request credit stall 0x2A, read 0x2B.
// - Subordinate: regulation stalls AW/AR outstanding 0x2C/0x2D, bandwidth 0x2E/0x2F.
// - Events without security attribute count only under secure debug.
// - Secure debug is ((SI and I) or SNI) and (I or NI).
// - Attributed events count when invasive or noninvasive enable is high.
// - Up to 64 events per unit, at most eight published.
// - Published events drive an 8-bit bus, bit n to counter n.
module axi_ni_perf_event_source
	import perf_event_pkg::*;
#(
	parameter bit subordinate_side = 1'b1,
	parameter bit persist_cmo_present = 1'b1,
	parameter int lanes = perf_event_pkg::bus_width
) (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Debug enables
	input wire logic invasive_debug_enable,
	input wire logic noninvasive_debug_enable,
	input wire logic secure_invasive_debug_enable,
	input wire logic secure_noninvasive_debug_enable,
	// Event selection, per lane
	input wire logic [lanes*perf_event_pkg::code_width-1:0] lane_code,
	input wire logic [lanes-1:0] lane_enable,
	// Read address channel
	input wire logic arvalid,
	input wire logic arready,
	input wire logic [3:0] arcache,
	input wire logic [3:0] arsnoop,
	input wire logic [1:0] ardomain,
	input wire logic [1:0] artagop,
	// Write address channel
	input wire logic awvalid,
	input wire logic awready,
	input wire logic [3:0] awcache,
	input wire logic [3:0] awsnoop,
	input wire logic [1:0] awdomain,
	input wire logic [1:0] awcmo,
	input wire logic [5:0] awatop,
	input wire logic [1:0] awtagop,
	// Data and response channels
	input wire logic rvalid,
	input wire logic rready,
	input wire logic rlast,
	input wire logic wvalid,
	input wire logic wready,
	input wire logic bvalid,
	input wire logic bready,
	// Internal stall causes
	input wire logic rd_tracker_full,
	input wire logic wr_tracker_full,
	input wire logic wr_credit_stall,
	input wire logic rd_credit_stall,
	input wire logic w_lowwire_stall,
	input wire logic r_lowwire_stall,
	input wire logic ot_limit_stall,
	input wire logic bw_limit_stall,
	input wire logic atomic_arb_stall,
	input wire logic wbuf_full_stall,
	input wire logic rob_full_stall,
	input wire logic aw_order_stall,
	input wire logic ar_order_stall,
	input wire logic atomic_rd_stall,
	input wire logic aw_ot_stall,
	input wire logic ar_ot_stall,
	input wire logic aw_bw_stall,
	input wire logic ar_bw_stall,
	// Counter bus
	output logic [lanes-1:0] event_bus
);
	import perf_event_pkg::*;
	default clocking check_clock @(posedge clock); endclocking
	default disable iff (reset);

	// ==========================================================
	// Debug qualification
	logic debug_on;
	logic secure_on;
	secure_debug_gate gate (
		.clock(clock),
		.reset(reset),
		.invasive_debug_enable(invasive_debug_enable),
		.noninvasive_debug_enable(noninvasive_debug_enable),
		.secure_invasive_debug_enable(secure_invasive_debug_enable),
		.secure_noninvasive_debug_enable(secure_noninvasive_debug_enable),
		.debug_on(debug_on),
		.secure_on(secure_on)
	);

	// ==========================================================
	// Raw conditions, one per cycle
	logic ar_hs, aw_hs, r_hs, w_hs;
	logic ar_dev, aw_dev, ar_cmo, aw_wcmo, aw_stash, aw_atomic;
	assign ar_hs = arvalid & arready;
	assign aw_hs = awvalid & awready;
	assign r_hs = rvalid & rready;
	assign w_hs = wvalid & wready;
	assign ar_dev = arcache[cache_dev_hi:cache_dev_lo] == cache_device;
	assign aw_dev = awcache[cache_dev_hi:cache_dev_lo] == cache_device;
	assign ar_cmo = (arsnoop == snoop_clean_shared) | (arsnoop == snoop_clean_invalid)
		| (arsnoop == snoop_make_invalid)
		| (persist_cmo_present & (arsnoop == snoop_clean_shared_persist));
	assign aw_wcmo = (awsnoop == snoop_wcmo_a) | (awsnoop == snoop_wcmo_b) | (awsnoop == snoop_wcmo_c);
	assign aw_stash = (awsnoop == snoop_stash_a) | (awsnoop == snoop_stash_b);
	assign aw_atomic = awatop != atop_none;

	// Attributed events carry the request security and need only debug on;
	// unattributed ones need secure debug so nothing secure leaks out.
	logic [event_count-1:0] plain_ev;
	logic [event_count-1:0] secure_ev;
	logic ar_nosnoop_dom, aw_nosnoop_dom;
	assign ar_nosnoop_dom = (ardomain == domain_noshare) | (ardomain == domain_system);
	assign aw_nosnoop_dom = (awdomain == domain_noshare) | (awdomain == domain_system);
	always_comb begin
		plain_ev = '0;
		secure_ev = '0;
		plain_ev[ev_rd_req] = ar_hs;
		plain_ev[ev_wr_req] = aw_hs;
		plain_ev[ev_rd_nosnoop] = ar_hs & ar_nosnoop_dom & (arsnoop == snoop_read_nosnoop);
		plain_ev[ev_wr_nosnoop] = aw_hs & aw_nosnoop_dom & (awsnoop == snoop_write_nosnoop)
			& ~aw_atomic;
		plain_ev[ev_rd_once] = ar_hs & ~ar_nosnoop_dom & (arsnoop == snoop_read_once);
		plain_ev[ev_wr_unique] = aw_hs & ~aw_nosnoop_dom & (awsnoop == snoop_write_unique)
			& ~aw_atomic;
		plain_ev[ev_wr_line_unique] = aw_hs & ~aw_nosnoop_dom & (awsnoop == snoop_write_line_unique);
		plain_ev[ev_cmo] = ar_hs & ar_cmo;
		plain_ev[ev_wr_atomic] = aw_hs & aw_atomic;
		plain_ev[ev_wr_stash] = aw_hs & aw_stash;
		plain_ev[ev_cmo_plain] = aw_hs & aw_wcmo & (awcmo != cmo_persist)
			& (awcmo != cmo_deep_persist);
		plain_ev[ev_cmo_persist] = aw_hs & aw_wcmo
			& ((awcmo == cmo_persist) | (awcmo == cmo_deep_persist));
		plain_ev[ev_rd_tag] = ar_hs & (artagop != tag_none);
		plain_ev[ev_wr_tag] = aw_hs & (awtagop != tag_none);
		plain_ev[ev_ar_stall] = arvalid & ~arready;
		plain_ev[ev_aw_stall] = awvalid & ~awready;
		secure_ev[ev_rd_beat] = r_hs;
		secure_ev[ev_rd_last] = r_hs & rlast;
		secure_ev[ev_wr_beat] = w_hs;
		secure_ev[ev_r_stall] = rvalid & ~rready;
		secure_ev[ev_w_stall] = wvalid & ~wready;
		secure_ev[ev_b_stall] = bvalid & ~bready;
		if (subordinate_side) begin
			plain_ev[ev_rd_device] = ar_hs & ar_dev;
			plain_ev[ev_wr_device] = aw_hs & aw_dev;
			plain_ev[ev_s_ot_limit] = ot_limit_stall;
			plain_ev[ev_s_bw_limit] = bw_limit_stall;
			plain_ev[ev_s_atomic_arb] = atomic_arb_stall;
			plain_ev[ev_s_rd_tracker] = rd_tracker_full;
			plain_ev[ev_s_wr_tracker] = wr_tracker_full;
			secure_ev[ev_s_wbuf_full] = wbuf_full_stall;
			plain_ev[ev_s_rob_full] = rob_full_stall;
			plain_ev[ev_s_aw_order] = aw_order_stall;
			plain_ev[ev_s_ar_order] = ar_order_stall;
			plain_ev[ev_s_atomic_rd] = atomic_rd_stall;
			secure_ev[ev_s_aw_credit] = wr_credit_stall;
			secure_ev[ev_s_ar_credit] = rd_credit_stall;
			plain_ev[ev_s_aw_ot] = aw_ot_stall;
			plain_ev[ev_s_ar_ot] = ar_ot_stall;
			plain_ev[ev_s_aw_bw] = aw_bw_stall;
			plain_ev[ev_s_ar_bw] = ar_bw_stall;
			secure_ev[ev_s_w_lowwire] = w_lowwire_stall;
			secure_ev[ev_s_r_lowwire] = r_lowwire_stall;
		end else begin
			// Device type is only classified on the subordinate side
			plain_ev[ev_m_rd_tracker] = rd_tracker_full;
			plain_ev[ev_m_wr_tracker] = wr_tracker_full;
			secure_ev[ev_m_b_credit] = wr_credit_stall;
			secure_ev[ev_m_r_credit] = rd_credit_stall;
			secure_ev[ev_m_b_lowwire] = w_lowwire_stall;
			secure_ev[ev_m_r_lowwire] = r_lowwire_stall;
		end
	end

	// ==========================================================
	// Registered qualified event lines
	typedef struct packed {
		logic [event_count-1:0] events;
	} state_type;
	state_type state_q, state_d;
	always_comb begin
		state_d.events = ({event_count{debug_on}} & plain_ev)
			| ({event_count{secure_on}} & secure_ev);
		if (reset) begin
			state_d.events = '0;
		end
	end
	always_ff @(posedge clock) begin
		state_q <= state_d;
	end

	event_select #(.lanes(lanes)) select (
		.clock(clock),
		.reset(reset),
		.events(state_q.events),
		.lane_code(lane_code),
		.lane_enable(lane_enable),
		.event_bus(event_bus)
	);

	// ==========================================================
	// Checks
	a_read_handshake: assert property (@(posedge clock) disable iff (reset)
		(ar_hs && debug_on) |=> state_q.events[ev_rd_req]) else $error("read request event missed");
	a_read_last_beat: assert property (@(posedge clock) disable iff (reset)
		state_q.events[ev_rd_last] |-> state_q.events[ev_rd_beat]) else $error("last beat without beat");
	a_write_beat: assert property (@(posedge clock) disable iff (reset)
		(w_hs && secure_on) |=> state_q.events[ev_wr_beat]) else $error("write beat missed");
	a_addr_stall: assert property (@(posedge clock) disable iff (reset)
		state_q.events[ev_ar_stall] |-> $past(arvalid) && !$past(arready)) else $error("bad read stall");
	a_secure_gated: assert property (@(posedge clock) disable iff (reset)
		!$past(secure_on) |-> !state_q.events[ev_rd_beat] && !state_q.events[ev_b_stall])
		else $error("secure-only event leaked");
	a_cmo_exclusive: assert property (@(posedge clock) disable iff (reset)
		!(state_q.events[ev_cmo_plain] && state_q.events[ev_cmo_persist])) else $error("both cmo kinds");
	a_plain_gated: assert property (@(posedge clock) disable iff (reset)
		!$past(debug_on) |-> !state_q.events[ev_wr_req]) else $error("event without debug");
	a_bus_delay: assert property (@(posedge clock) disable iff (reset)
		(lane_enable[0] && $stable(lane_code) && state_q.events[lane_code[code_width-1:0]])
		|=> event_bus[0]) else $error("bus lane 0 missed");

	// ==========================================================
	// Stall and attribute checks, one cycle after the condition
	a_read_data_stall: assert property ((rvalid && !rready && secure_on) |=> state_q.events[ev_r_stall])
		else $error("read data stall missed");

	a_resp_stall: assert property ((bvalid && !bready && secure_on) |=> state_q.events[ev_b_stall])
		else $error("response stall missed");

	a_device_read: assert property (state_q.events[ev_rd_device] |-> $past(ar_hs)
		&& $past(arcache[cache_dev_hi:cache_dev_lo]) == cache_device) else $error("device read without device cache");

	a_tag_write: assert property (state_q.events[ev_wr_tag] |-> $past(aw_hs) && $past(awtagop) != tag_none)
		else $error("tag write event without tag");

	a_nosnoop_read: assert property (state_q.events[ev_rd_nosnoop] |-> $past(arsnoop) == snoop_read_nosnoop)
		else $error("non-snooping read with wrong snoop");

	a_line_unique: assert property (state_q.events[ev_wr_line_unique]
		|-> $past(awsnoop) == snoop_write_line_unique) else $error("line unique event with wrong snoop");

	a_cmo_read: assert property (state_q.events[ev_cmo] |-> $past(ar_hs))
		else $error("maintenance event without read request");

	a_atomic_write: assert property ((aw_hs && awatop != atop_none && debug_on)
		|=> state_q.events[ev_wr_atomic]) else $error("atomic write missed");

	a_tracker_stall: assert property ((subordinate_side && rd_tracker_full && debug_on)
		|=> state_q.events[ev_s_rd_tracker]) else $error("read tracker stall missed");

	a_lowwire_gated: assert property (!secure_on |=> !state_q.events[ev_s_w_lowwire])
		else $error("low-wire stall leaked");

	a_limit_stall: assert property ((subordinate_side && ot_limit_stall && debug_on)
		|=> state_q.events[ev_s_ot_limit]) else $error("outstanding limit stall missed");

	a_atomic_collide: assert property ((subordinate_side && atomic_arb_stall && debug_on)
		|=> state_q.events[ev_s_atomic_arb]) else $error("atomic collision stall missed");

	a_wbuf_stall: assert property ((subordinate_side && wbuf_full_stall && secure_on)
		|=> state_q.events[ev_s_wbuf_full]) else $error("write buffer stall missed");

	a_order_stall: assert property ((subordinate_side && ar_order_stall && debug_on)
		|=> state_q.events[ev_s_ar_order]) else $error("read ordering stall missed");

	a_credit_stall: assert property ((subordinate_side && rd_credit_stall && secure_on)
		|=> state_q.events[ev_s_ar_credit]) else $error("read credit stall missed");

	a_regulation_stall: assert property ((subordinate_side && aw_bw_stall && debug_on)
		|=> state_q.events[ev_s_aw_bw]) else $error("write bandwidth stall missed");

	a_bus_enable: assert property (!lane_enable[0] |=> !event_bus[0])
		else $error("disabled lane 0 published");

	// ==========================================================
	// Coverage
	c_credit_stall: cover property (@(posedge clock) disable iff (reset) state_q.events[ev_s_ar_credit]);
	c_debug_off: cover property (@(posedge clock) disable iff (reset) ar_hs && !debug_on);
	c_read_burst: cover property (@(posedge clock) disable iff (reset)
		state_q.events[ev_rd_beat] ##1 state_q.events[ev_rd_last]);
	c_write_stall: cover property (@(posedge clock) disable iff (reset) state_q.events[ev_aw_stall]);
	c_bus_active: cover property (@(posedge clock) disable iff (reset) event_bus != '0);
endmodule

//--- verification/axi_traffic_model.sv
// Far-side traffic model: both AXI ends around the event source
`timescale 1ns/1ps
module axi_traffic_model (
	// Clock and reset
	input wire logic clock,
	input wire logic reset,
	// Control
	input wire logic active,
	input wire logic slow,
	// Read address channel
	output logic arvalid,
	output logic arready,
	output logic [3:0] arcache,
	output logic [3:0] arsnoop,
	output logic [1:0] ardomain,
	output logic [1:0] artagop,
	// Write address channel
	output logic awvalid,
	output logic awready,
	output logic [3:0] awcache,
	output logic [3:0] awsnoop,
	output logic [1:0] awdomain,
	output logic [1:0] awcmo,
	output logic [5:0] awatop,
	output logic [1:0] awtagop,
	// Data and response channels
	output logic rvalid,
	output logic rready,
	output logic rlast,
	output logic wvalid,
	output logic wready,
	output logic bvalid,
	output logic bready
);
	logic go;
	assign go = active && !reset;
	function automatic logic pick();
		return slow ? ($urandom_range(3) == 0) : ($urandom_range(3) != 0);
	endfunction
	initial begin
		{arvalid, arready, arcache, arsnoop, ardomain, artagop} = '0;
		{awvalid, awready, awcache, awsnoop, awdomain, awcmo, awatop, awtagop} = '0;
		{rvalid, rready, rlast, wvalid, wready, bvalid, bready} = '0;
	end
	// A valid holds with its attributes until its handshake; readies go high when idle so all drains
	always @(posedge clock) begin
		{arready, awready, rready, wready, bready} <= {5{!go}} | {pick(), pick(), pick(), pick(), pick()};
		if (!arvalid || arready) begin
			arvalid <= go && pick();
			{arcache, arsnoop, ardomain, artagop} <= 12'($urandom);
		end
		if (!awvalid || awready) begin
			awvalid <= go && pick();
			{awcache, awsnoop, awdomain, awcmo, awtagop} <= 14'($urandom);
			awatop <= ($urandom_range(3) == 0) ? 6'($urandom) : 6'h00;
		end
		if (!rvalid || rready) begin
			rvalid <= go && pick();
			rlast <= 1'($urandom);
		end
		if (!wvalid || wready) begin
			wvalid <= go && pick();
		end
		if (!bvalid || bready) begin
			bvalid <= go && pick();
		end
	end
endmodule

//--- verification/testbench.sv
// Self-checking bench for the interface event source
`timescale 1ns/1ps
module testbench;
	logic clock, reset, active, slow;
	logic [3:0] debug_en;
	logic [47:0] lane_code;
	logic [7:0] lane_enable, event_bus, want;
	logic [17:0] stall;
	logic arvalid, arready, awvalid, awready, rvalid, rready, rlast, wvalid, wready, bvalid, bready;
	logic [3:0] arcache, arsnoop, awcache, awsnoop;
	logic [1:0] ardomain, artagop, awdomain, awcmo, awtagop;
	logic [5:0] awatop;
	logic [7:0] expected_q[$];
	int err_count = 0;
	int n_tests = 0;
	int cycles = 0;
	// ==========================================
	// Design and far side
	axi_traffic_model partner (.clock(clock), .reset(reset), .active(active), .slow(slow),
		.arvalid(arvalid), .arready(arready), .arcache(arcache), .arsnoop(arsnoop), .ardomain(ardomain),
		.artagop(artagop), .awvalid(awvalid), .awready(awready), .awcache(awcache), .awsnoop(awsnoop),
		.awdomain(awdomain), .awcmo(awcmo), .awatop(awatop), .awtagop(awtagop), .rvalid(rvalid),
		.rready(rready), .rlast(rlast), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready));
	axi_ni_perf_event_source #(.subordinate_side(1'b1), .persist_cmo_present(1'b1), .lanes(8)) DUT (
		.clock(clock), .reset(reset), .invasive_debug_enable(debug_en[0]),
		.noninvasive_debug_enable(debug_en[1]), .secure_invasive_debug_enable(debug_en[2]),
		.secure_noninvasive_debug_enable(debug_en[3]), .lane_code(lane_code), .lane_enable(lane_enable),
		.arvalid(arvalid), .arready(arready), .arcache(arcache), .arsnoop(arsnoop), .ardomain(ardomain),
		.artagop(artagop), .awvalid(awvalid), .awready(awready), .awcache(awcache), .awsnoop(awsnoop),
		.awdomain(awdomain), .awcmo(awcmo), .awatop(awatop), .awtagop(awtagop), .rvalid(rvalid),
		.rready(rready), .rlast(rlast), .wvalid(wvalid), .wready(wready), .bvalid(bvalid), .bready(bready),
		.ot_limit_stall(stall[0]), .bw_limit_stall(stall[1]), .atomic_arb_stall(stall[2]),
		.rd_tracker_full(stall[3]), .wr_tracker_full(stall[4]), .wbuf_full_stall(stall[5]),
		.rob_full_stall(stall[6]), .aw_order_stall(stall[7]), .ar_order_stall(stall[8]),
		.atomic_rd_stall(stall[9]), .wr_credit_stall(stall[10]), .rd_credit_stall(stall[11]),
		.aw_ot_stall(stall[12]), .ar_ot_stall(stall[13]), .aw_bw_stall(stall[14]), .ar_bw_stall(stall[15]),
		.w_lowwire_stall(stall[16]), .r_lowwire_stall(stall[17]), .event_bus(event_bus));
	always #2 clock = ~clock;
	// ==========================================
	// Expected bus from the inputs sampled at one edge
	function automatic logic [7:0] expect_bus();
		logic [63:0] ev;
		logic [7:0] res;
		logic ar_hs, aw_hs, r_hs, dbg, sec;
		ar_hs = arvalid && arready;
		aw_hs = awvalid && awready;
		r_hs = rvalid && rready;
		ev = '0;
		ev[6'h00] = ar_hs;
		ev[6'h07] = aw_hs;
		ev[6'h05] = r_hs;
		ev[6'h06] = r_hs && rlast;
		ev[6'h0D] = wvalid && wready;
		ev[6'h0E] = arvalid && !arready;
		ev[6'h10] = awvalid && !awready;
		ev[6'h0F] = rvalid && !rready;
		ev[6'h11] = wvalid && !wready;
		ev[6'h12] = bvalid && !bready;
		ev[6'h01] = ar_hs && arcache[3:1] == 3'h0;
		ev[6'h08] = aw_hs && awcache[3:1] == 3'h0;
		ev[6'h14] = aw_hs && awsnoop inside {4'h6, 4'hA, 4'hB} && !(awcmo inside {2'h2, 2'h3});
		ev[6'h15] = aw_hs && awsnoop inside {4'h6, 4'hA, 4'hB} && awcmo inside {2'h2, 2'h3};
		ev[6'h16] = ar_hs && artagop != 2'h0;
		ev[6'h17] = aw_hs && awtagop != 2'h0;
		ev[6'h02] = ar_hs && arsnoop == 4'h0 && ardomain inside {2'h0, 2'h3};
		ev[6'h09] = aw_hs && awsnoop == 4'h0 && awdomain inside {2'h0, 2'h3} && awatop == 6'h00;
		ev[6'h03] = ar_hs && arsnoop == 4'h0 && ardomain inside {2'h1, 2'h2};
		ev[6'h0A] = aw_hs && awsnoop == 4'h1 && awdomain inside {2'h1, 2'h2};
		ev[6'h0B] = aw_hs && awsnoop == 4'h0 && awdomain inside {2'h1, 2'h2} && awatop == 6'h00;
		ev[6'h04] = ar_hs && arsnoop inside {4'h8, 4'h9, 4'hD, 4'hA};
		ev[6'h0C] = aw_hs && awatop != 6'h00;
		ev[6'h13] = aw_hs && awsnoop inside {4'hC, 4'hD};
		ev[49:32] = stall;
		dbg = debug_en[0] || debug_en[1];
		sec = ((debug_en[2] && debug_en[0]) || debug_en[3]) && dbg;
		ev = (ev & 64'h0003_0C20_0006_A060 & {64{sec}}) | (ev & ~64'h0003_0C20_0006_A060 & {64{dbg}});
		for (int n = 0; n < 8; n++) begin
			res[n] = lane_enable[n] && ev[lane_code[6*n +: 6]];
		end
		return res;
	endfunction
	always @(posedge clock) begin
		if (!reset) begin
			expected_q.push_back(expect_bus());
		end
	end
	// Bus answers one edge after the inputs are taken: event register, then bus register
	always @(negedge clock) begin
		if (expected_q.size() >= 2) begin
			want = expected_q.pop_front();
			n_tests++;
			if (event_bus !== want) begin
				err_count++;
				$display("Error: event_bus expected %h seen %h", want, event_bus);
			end
		end
	end
	// ==========================================
	// Stimulus
	task automatic give_verdict();
		$display("Checks %0d, mismatches %0d", n_tests, err_count);
		if (err_count == 0 && n_tests > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask
	// Lane codes and enables only change while the channels are silent, so select latency never matters
	task automatic quiet();
		@(posedge clock);
		active <= 1'b0;
		stall <= '0;
		repeat (6) @(posedge clock);
	endtask
	task automatic run_phase(input int ph);
		quiet();
		for (int k = 0; k < 8; k++) begin
			lane_code[6*k +: 6] <= 6'((ph % 8) * 8 + k);
		end
		debug_en <= (ph < 8) ? 4'hF : ((ph < 24) ? 4'(ph - 8) : 4'($urandom));
		lane_enable <= (ph < 8) ? 8'hFF : 8'($urandom | $urandom);
		slow <= 1'(ph % 2);
		repeat (4) @(posedge clock);
		active <= 1'b1;
		for (int k = 0; k < 150; k++) begin
			@(posedge clock);
			stall <= 18'($urandom & $urandom);
		end
	endtask
	always @(posedge clock) begin
		cycles++;
		if (cycles == 20000) begin
			err_count++;
			give_verdict();
		end
	end
	initial begin
		clock = 1'b0;
		reset = 1'b1;
		active = 1'b0;
		slow = 1'b0;
		stall = '0;
		debug_en = 4'h0;
		lane_code = '0;
		lane_enable = 8'h00;
		void'($urandom(32'hfd5c_d7b5));
		repeat (4) @(posedge clock);
		reset <= 1'b0;
		for (int ph = 0; ph < 32; ph++) begin
			run_phase(ph);
		end
		quiet();
		give_verdict();
	end
endmodule
